// File: hdl/payload_ctrl_pkg.sv
// constants shared by the payload control indirect access block
package payload_ctrl_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_PAYLOAD_CFG_OFS           = 8'h5C;
  localparam logic [7:0] RX_PAYLOAD_ACCESS_STATUS_OFS = 8'h5D;
  localparam logic [7:0] TX_PAYLOAD_CFG_OFS           = 8'h60;
  localparam logic [7:0] TX_PAYLOAD_ACCESS_STATUS_OFS = 8'h61;
  localparam logic [7:0] RX_SIGNALING_BUF_CFG_OFS     = 8'h64;
  localparam logic [7:0] RX_SIGNALING_BUF_STATUS_OFS  = 8'h65;
  localparam logic [7:0] RX_PAYLOAD_INDIRECT_ADDR_OFS = 8'hDE;
  localparam logic [7:0] RX_PAYLOAD_INDIRECT_DATA_OFS = 8'hDF;
  localparam logic [7:0] TX_PAYLOAD_INDIRECT_ADDR_OFS = 8'hE2;
  localparam logic [7:0] TX_PAYLOAD_INDIRECT_DATA_OFS = 8'hE3;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         BLOCK_ACCESS_ENABLE_BIT = 0;
  localparam int         BUSY_BIT                = 7;
  localparam int         READ_SEL_BIT            = 7;
  localparam int         TX_TEST_BIT             = 3;
  localparam int         RX_TEST_BIT             = 7;
  localparam int         TS_BASE                 = 32;
  localparam int         NUM_TS                  = 32;
  localparam int         TABLE_ENTRIES           = 128;
  localparam int         INDEX_W                 = 7;
  localparam logic [7:0] REG_RESET               = 8'h00;
  localparam logic [7:0] UNMAPPED_READ           = 8'h00;

  // ----------------------------------------------------------------
  // timing: cycles of busy before an entry transfer completes
  // ----------------------------------------------------------------
  localparam int         XFER_CYCLES             = 4;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_RUN  = 2'b01,
    XFER_DONE = 2'b11
  } xfer_state_t;

endpackage : payload_ctrl_pkg

// File: hdl/indirect_table.sv
// one indirect control table with its busy-timed transfer engine
module indirect_table #(
  parameter int ENTRIES     = payload_ctrl_pkg::TABLE_ENTRIES,
  parameter int TEST_BIT    = payload_ctrl_pkg::TX_TEST_BIT,
  parameter int XFER_CYCLES = payload_ctrl_pkg::XFER_CYCLES,
  parameter int NUM_TS      = payload_ctrl_pkg::NUM_TS
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              start,
  input  wire logic              rw_read,
  input  wire logic [6:0]        index,
  input  wire logic [7:0]        wdata,
  output logic                   busy,
  output logic                   rd_done,
  output logic [7:0]             rd_value,
  output logic [NUM_TS-1:0]      test_mask
);

  localparam int CNT_W = $clog2(XFER_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(XFER_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);

  payload_ctrl_pkg::xfer_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [6:0]       idx_reg;
  logic [7:0]       data_reg;
  logic             read_reg;
  logic [7:0]       table_reg [ENTRIES];

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  // a start while disabled or busy is dropped; the top already filters it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= payload_ctrl_pkg::XFER_IDLE;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        payload_ctrl_pkg::XFER_IDLE: begin
          if (start && enable) begin
            state_reg <= payload_ctrl_pkg::XFER_RUN;
            cnt_reg   <= CNT_LOAD;
          end
        end
        payload_ctrl_pkg::XFER_RUN: begin
          if (cnt_reg == CNT_LAST) begin
            state_reg <= payload_ctrl_pkg::XFER_DONE;
          end
          cnt_reg <= cnt_reg - CNT_LAST;
        end
        default: begin
          state_reg <= payload_ctrl_pkg::XFER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg  <= '0;
      data_reg <= payload_ctrl_pkg::REG_RESET;
      read_reg <= 1'b0;
    end else if (state_reg == payload_ctrl_pkg::XFER_IDLE && start && enable) begin
      idx_reg  <= index;
      data_reg <= wdata;
      read_reg <= rw_read;
    end
  end

  // entry moves only at the end of the last run cycle, one cycle before busy drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        table_reg[i] <= payload_ctrl_pkg::REG_RESET;
      end
    end else if (state_reg == payload_ctrl_pkg::XFER_RUN && cnt_reg == CNT_LAST
                 && !read_reg) begin
      table_reg[idx_reg] <= data_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_done  <= 1'b0;
      rd_value <= payload_ctrl_pkg::REG_RESET;
    end else begin
      rd_done <= state_reg == payload_ctrl_pkg::XFER_RUN && cnt_reg == CNT_LAST && read_reg;
      if (state_reg == payload_ctrl_pkg::XFER_RUN && cnt_reg == CNT_LAST && read_reg) begin
        rd_value <= table_reg[idx_reg];
      end
    end
  end

  assign busy = state_reg != payload_ctrl_pkg::XFER_IDLE;

  // ----------------------------------------------------------------
  // per-timeslot test-pattern routing
  // ----------------------------------------------------------------
  for (genvar t = 0; t < NUM_TS; t++) begin : g_ts
    assign test_mask[t] = enable && table_reg[payload_ctrl_pkg::TS_BASE + t][TEST_BIT];
  end

endmodule : indirect_table

// File: hdl/payload_ctrl_indirect_access.sv
// register bank and indirect access path for the payload control tables
//
// Summary of operation
// - block works only while config bit0 set
// - busy in status bit7; access only when clear
// - data 08H then 20H+timeslot sets transmit test
// - data 80H then entry address sets receive test
module payload_ctrl_indirect_access #(
  parameter int XFER_CYCLES = payload_ctrl_pkg::XFER_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  output logic      [31:0] tx_test_ts,
  output logic      [31:0] rx_test_ts,
  output logic             rx_signaling_buffer_en
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] rx_payload_cfg_reg;
  logic [7:0] tx_payload_cfg_reg;
  logic [7:0] rx_signaling_buf_cfg_reg;
  logic [7:0] rx_addr_reg;
  logic [7:0] rx_data_reg;
  logic [7:0] tx_addr_reg;
  logic [7:0] tx_data_reg;
  logic [7:0] rd_next;
  logic       rx_busy;
  logic       tx_busy;
  logic       rx_rd_done;
  logic       tx_rd_done;
  logic [7:0] rx_rd_value;
  logic [7:0] tx_rd_value;
  logic       rx_en;
  logic       tx_en;
  logic       rx_start;
  logic       tx_start;

  assign rx_en = rx_payload_cfg_reg[payload_ctrl_pkg::BLOCK_ACCESS_ENABLE_BIT];
  assign tx_en = tx_payload_cfg_reg[payload_ctrl_pkg::BLOCK_ACCESS_ENABLE_BIT];
  assign rx_signaling_buffer_en =
    rx_signaling_buf_cfg_reg[payload_ctrl_pkg::BLOCK_ACCESS_ENABLE_BIT];

  // an address write is the trigger; it is refused while busy or disabled
  assign rx_start = reg_wr && reg_addr == payload_ctrl_pkg::RX_PAYLOAD_INDIRECT_ADDR_OFS
                    && !rx_busy && rx_en;
  assign tx_start = reg_wr && reg_addr == payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_ADDR_OFS
                    && !tx_busy && tx_en;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_payload_cfg_reg       <= payload_ctrl_pkg::REG_RESET;
      tx_payload_cfg_reg       <= payload_ctrl_pkg::REG_RESET;
      rx_signaling_buf_cfg_reg <= payload_ctrl_pkg::REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == payload_ctrl_pkg::RX_PAYLOAD_CFG_OFS) begin
        rx_payload_cfg_reg <= reg_wdata;
      end else if (reg_addr == payload_ctrl_pkg::TX_PAYLOAD_CFG_OFS) begin
        tx_payload_cfg_reg <= reg_wdata;
      end else if (reg_addr == payload_ctrl_pkg::RX_SIGNALING_BUF_CFG_OFS) begin
        rx_signaling_buf_cfg_reg <= reg_wdata;
      end
    end
  end

  // staging registers ignore host writes while a transfer runs; a finished read still loads its result into data
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_addr_reg <= payload_ctrl_pkg::REG_RESET;
      rx_data_reg <= payload_ctrl_pkg::REG_RESET;
    end else if (rx_rd_done) begin
      rx_data_reg <= rx_rd_value;
    end else if (reg_wr && !rx_busy) begin
      if (reg_addr == payload_ctrl_pkg::RX_PAYLOAD_INDIRECT_ADDR_OFS) begin
        rx_addr_reg <= reg_wdata;
      end else if (reg_addr == payload_ctrl_pkg::RX_PAYLOAD_INDIRECT_DATA_OFS) begin
        rx_data_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_addr_reg <= payload_ctrl_pkg::REG_RESET;
      tx_data_reg <= payload_ctrl_pkg::REG_RESET;
    end else if (tx_rd_done) begin
      tx_data_reg <= tx_rd_value;
    end else if (reg_wr && !tx_busy) begin
      if (reg_addr == payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_ADDR_OFS) begin
        tx_addr_reg <= reg_wdata;
      end else if (reg_addr == payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_DATA_OFS) begin
        tx_data_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // the signaling buffer has no indirect port here, so its busy reads 0
  always_comb begin
    rd_next = payload_ctrl_pkg::UNMAPPED_READ;
    if (reg_addr == payload_ctrl_pkg::RX_PAYLOAD_CFG_OFS) begin
      rd_next = rx_payload_cfg_reg;
    end else if (reg_addr == payload_ctrl_pkg::RX_PAYLOAD_ACCESS_STATUS_OFS) begin
      rd_next[payload_ctrl_pkg::BUSY_BIT] = rx_busy;
    end else if (reg_addr == payload_ctrl_pkg::TX_PAYLOAD_CFG_OFS) begin
      rd_next = tx_payload_cfg_reg;
    end else if (reg_addr == payload_ctrl_pkg::TX_PAYLOAD_ACCESS_STATUS_OFS) begin
      rd_next[payload_ctrl_pkg::BUSY_BIT] = tx_busy;
    end else if (reg_addr == payload_ctrl_pkg::RX_SIGNALING_BUF_CFG_OFS) begin
      rd_next = rx_signaling_buf_cfg_reg;
    end else if (reg_addr == payload_ctrl_pkg::RX_PAYLOAD_INDIRECT_ADDR_OFS) begin
      rd_next = rx_addr_reg;
    end else if (reg_addr == payload_ctrl_pkg::RX_PAYLOAD_INDIRECT_DATA_OFS) begin
      rd_next = rx_data_reg;
    end else if (reg_addr == payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_ADDR_OFS) begin
      rd_next = tx_addr_reg;
    end else if (reg_addr == payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_DATA_OFS) begin
      rd_next = tx_data_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata  <= payload_ctrl_pkg::REG_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // indirect tables
  // ----------------------------------------------------------------
  indirect_table #(
    .ENTRIES     (payload_ctrl_pkg::TABLE_ENTRIES),
    .TEST_BIT    (payload_ctrl_pkg::RX_TEST_BIT),
    .XFER_CYCLES (XFER_CYCLES),
    .NUM_TS      (payload_ctrl_pkg::NUM_TS)
  ) u_rx_payload_ctrl (
    .clk       (ref_clk),
    .rst_n     (rst_sync_n),
    .enable    (rx_en),
    .start     (rx_start),
    .rw_read   (reg_wdata[payload_ctrl_pkg::READ_SEL_BIT]),
    .index     (reg_wdata[payload_ctrl_pkg::INDEX_W-1:0]),
    .wdata     (rx_data_reg),
    .busy      (rx_busy),
    .rd_done   (rx_rd_done),
    .rd_value  (rx_rd_value),
    .test_mask (rx_test_ts)
  );

  indirect_table #(
    .ENTRIES     (payload_ctrl_pkg::TABLE_ENTRIES),
    .TEST_BIT    (payload_ctrl_pkg::TX_TEST_BIT),
    .XFER_CYCLES (XFER_CYCLES),
    .NUM_TS      (payload_ctrl_pkg::NUM_TS)
  ) u_tx_payload_ctrl (
    .clk       (ref_clk),
    .rst_n     (rst_sync_n),
    .enable    (tx_en),
    .start     (tx_start),
    .rw_read   (reg_wdata[payload_ctrl_pkg::READ_SEL_BIT]),
    .index     (reg_wdata[payload_ctrl_pkg::INDEX_W-1:0]),
    .wdata     (tx_data_reg),
    .busy      (tx_busy),
    .rd_done   (tx_rd_done),
    .rd_value  (tx_rd_value),
    .test_mask (tx_test_ts)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // figures assume the default of four transfer cycles
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_rx_disabled_quiet;
    // a transfer already running when the host disables may finish
    !rx_en |-> rx_test_ts == '0 && (!rx_busy || $past(rx_busy));
  endproperty
  a_rx_disabled_quiet: assert property (p_rx_disabled_quiet)
    else $error("receive table active while disabled");

  property p_tx_busy_window;
    tx_start |=> tx_busy [*5] ##1 !tx_busy;
  endproperty
  a_tx_busy_window: assert property (p_tx_busy_window)
    else $error("transmit busy window has wrong length");

  property p_status_busy;
    reg_rd && reg_addr == payload_ctrl_pkg::TX_PAYLOAD_ACCESS_STATUS_OFS
      |=> reg_rvalid && reg_rdata[payload_ctrl_pkg::BUSY_BIT] == $past(tx_busy);
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("status busy bit does not match engine");

  property p_data_held_busy;
    reg_wr && reg_addr == payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_DATA_OFS
      && tx_busy && !tx_rd_done |=> $stable(tx_data_reg);
  endproperty
  a_data_held_busy: assert property (p_data_held_busy)
    else $error("data register changed during transfer");

  property p_tx_test_ts2;
    tx_start && reg_wdata == 8'h22 && tx_data_reg == 8'h08 |-> ##[1:6] tx_test_ts[2];
  endproperty
  a_tx_test_ts2: assert property (p_tx_test_ts2)
    else $error("transmit test bit for timeslot 2 not set");

  property p_rx_test_ts4;
    rx_start && reg_wdata == 8'h24 && rx_data_reg == 8'h80 |-> ##[1:6] rx_test_ts[4];
  endproperty
  a_rx_test_ts4: assert property (p_rx_test_ts4)
    else $error("receive test bit for timeslot 4 not set");

  property p_tx_change_at_end;
    // the entry lands one cycle before busy drops
    $changed(tx_test_ts) |-> $changed(tx_en) or ##1 $fell(tx_busy);
  endproperty
  a_tx_change_at_end: assert property (p_tx_change_at_end)
    else $error("transmit entry changed outside transfer end");

  c_tx_write: cover property (tx_start ##[1:6] $fell(tx_busy));
  c_rx_read: cover property (rx_start && reg_wdata[7] ##[1:6] rx_rd_done);
  c_refused: cover property (reg_wr && reg_addr ==
    payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_ADDR_OFS && tx_busy);

endmodule : payload_ctrl_indirect_access

// File: dv/host_model.sv
// host processor model that drives the register bus of the payload control block
module host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            hang
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr  = 8'hFF;
    reg_wdata = 8'hFF;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    hang      = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    // released lines show inverted values so nothing leans on stale bits
    reg_addr  <= ~addr;
    reg_wdata <= ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    int n;
    @(posedge ref_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;
    data = 8'hXX;
    for (n = 0; n < 8; n++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        data = reg_rdata;
        break;
      end
      @(posedge ref_clk);
    end
    if (n == 8) hang = 1'b1;
  endtask : rd

  // ----------------------------------------------------------------
  // indirect access
  // ----------------------------------------------------------------
  task automatic wait_idle(input logic [7:0] status_ofs);
    logic [7:0] s;
    int         n;
    for (n = 0; n < 20; n++) begin
      rd(status_ofs, s);
      if (s[payload_ctrl_pkg::BUSY_BIT] === 1'b0) break;
    end
    if (n == 20) hang = 1'b1;
  endtask : wait_idle

  // address register sits one below its data register in both tables
  task automatic ind_write(input logic [7:0] data_ofs, input logic [7:0] status_ofs,
                           input logic [7:0] data, input logic [7:0] entry);
    wait_idle(status_ofs);
    wr(data_ofs, data);
    wr(data_ofs - 8'h01, entry);
  endtask : ind_write
endmodule : host_model

// File: dv/payload_ctrl_indirect_access_bench.sv
// self-checking bench for the payload control indirect access block
module payload_ctrl_indirect_access_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_rvalid;
  logic [31:0] tx_test_ts;
  logic [31:0] rx_test_ts;
  logic        rx_signaling_buffer_en;
  logic        hang;
  logic [7:0]  v;
  int          errors;
  int          check_count;
  int          i;

  localparam logic [7:0] TXD = payload_ctrl_pkg::TX_PAYLOAD_INDIRECT_DATA_OFS;
  localparam logic [7:0] RXD = payload_ctrl_pkg::RX_PAYLOAD_INDIRECT_DATA_OFS;
  localparam logic [7:0] TXS = payload_ctrl_pkg::TX_PAYLOAD_ACCESS_STATUS_OFS;
  localparam logic [7:0] RXS = payload_ctrl_pkg::RX_PAYLOAD_ACCESS_STATUS_OFS;
  localparam logic [7:0] TXC = payload_ctrl_pkg::TX_PAYLOAD_CFG_OFS;
  localparam logic [7:0] SBC = payload_ctrl_pkg::RX_SIGNALING_BUF_CFG_OFS;
  localparam logic [7:0] REGS [6] = '{8'h5C, 8'h5D, 8'h60, 8'h61, 8'h64, 8'h65};

  host_model host (
    .ref_clk    (ref_clk),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .hang       (hang)
  );

  payload_ctrl_indirect_access dut (
    .ref_clk                (ref_clk),
    .rst_n                  (rst_n),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .reg_rvalid             (reg_rvalid),
    .tx_test_ts             (tx_test_ts),
    .rx_test_ts             (rx_test_ts),
    .rx_signaling_buffer_en (rx_signaling_buffer_en)
  );

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check32

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // a stuck poll or a missing read response both end here
  always @(posedge hang) begin
    errors++;
    final_report();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n       = 1'b0;
    errors      = 0;
    check_count = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    foreach (REGS[k]) begin
      host.rd(REGS[k], v);
      check8(v, payload_ctrl_pkg::REG_RESET);
    end
    host.wr(8'h70, 8'h55);
    host.rd(8'h70, v);
    check8(v, payload_ctrl_pkg::UNMAPPED_READ);
    host.wr(TXC, 8'hA4);
    host.rd(TXC, v);
    check8(v, 8'hA4);
    // table still disabled: the trigger must start nothing
    host.ind_write(TXD, TXS, 8'h08, 8'h22);
    host.rd(TXS, v);
    check8(v, 8'h00);
    check32(tx_test_ts, 32'h0000_0000);
    host.wr(payload_ctrl_pkg::RX_PAYLOAD_CFG_OFS, 8'h01);
    host.wr(TXC, 8'h01);
    host.wr(TXS, 8'hFF);
    host.rd(TXS, v);
    check8(v, 8'h00);
    for (i = 0; i < 64; i++) begin
      host.ind_write(TXD, TXS, 8'h00, 8'(i < 32 ? 32 + i : 64 + i));
    end
    for (i = 32; i < 64; i++) host.ind_write(RXD, RXS, 8'h00, 8'(i));
    host.wait_idle(TXS);
    check32(tx_test_ts, 32'h0000_0000);
    // busy must be visible right after the trigger
    host.wr(TXD, 8'h08);
    host.wr(TXD - 8'h01, 8'h22);
    host.rd(TXS, v);
    check8(v, 8'h80);
    host.ind_write(TXD, TXS, 8'h08, 8'h24);
    host.ind_write(TXD, TXS, 8'h08, 8'h25);
    host.wait_idle(TXS);
    check32(tx_test_ts, 32'h0000_0034);
    host.ind_write(RXD, RXS, 8'h80, 8'h22);
    host.rd(RXS, v);
    check8(v, 8'h80);
    host.ind_write(RXD, RXS, 8'h80, 8'h24);
    host.ind_write(RXD, RXS, 8'h80, 8'h25);
    host.wait_idle(RXS);
    check32(rx_test_ts, 32'h0000_0034);
    // data write during busy is dropped, readback shows the staged byte
    host.ind_write(TXD, TXS, 8'h08, 8'h26);
    host.wr(TXD, 8'hFF);
    host.wait_idle(TXS);
    host.rd(TXD, v);
    check8(v, 8'h08);
    host.wr(TXD - 8'h01, 8'hA6);
    host.wait_idle(TXS);
    host.rd(TXD, v);
    check8(v, 8'h08);
    check32(tx_test_ts, 32'h0000_0074);
    host.wr(RXD - 8'h01, 8'hA4);
    host.wait_idle(RXS);
    host.rd(RXD, v);
    check8(v, 8'h80);
    host.wr(TXC, 8'h00);
    host.rd(TXC, v);
    check32(tx_test_ts, 32'h0000_0000);
    host.wr(TXC, 8'h01);
    host.rd(TXC, v);
    check32(tx_test_ts, 32'h0000_0074);
    host.wr(SBC, 8'h01);
    host.rd(SBC, v);
    check8({7'h00, rx_signaling_buffer_en}, 8'h01);
    host.rd(payload_ctrl_pkg::RX_SIGNALING_BUF_STATUS_OFS, v);
    check8(v, 8'h00);
    host.wr(SBC, 8'h00);
    host.rd(SBC, v);
    check8({7'h00, rx_signaling_buffer_en}, 8'h00);
    final_report();
  end
endmodule : payload_ctrl_indirect_access_bench
